// ==== src/csl_link_if.sv ====
// serial link pins between loader host and crosspoint device
`timescale 1ns/1ps
interface csl_link_if;
	logic shift_clk;
	logic serial_data;
	logic latch_en;
	logic power_save_pin;
	logic cascade_serial_out;
	modport dev (
		input shift_clk,
		input serial_data,
		input latch_en,
		input power_save_pin,
		output cascade_serial_out
	);
	modport host (
		output shift_clk,
		output serial_data,
		output latch_en,
		output power_save_pin,
		input cascade_serial_out
	);
endinterface

// ==== src/csl_loader_host.sv ====
// loader host end: apb registers in, serial load sequence out
`timescale 1ns/1ps
module csl_loader_host #(
	parameter int MATRIX_N = csl_pkg::CSL_N_8X8,
	parameter int LEN = (MATRIX_N == csl_pkg::CSL_N_4X4) ?
		csl_pkg::CSL_BITS_4X4 : csl_pkg::CSL_BITS_WIDE
) (
	input logic pclk,
	input logic presetn,
	input logic psel,
	input logic penable,
	input logic pwrite,
	input logic [csl_pkg::CSL_APB_AW-1:0] paddr,
	input logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	csl_link_if.host link
);
	import csl_pkg::*;

	localparam logic [LEN-1:0] FORCED = (MATRIX_N == CSL_N_6X6) ?
		LEN'(CSL_FORCED_LOW_6X6) : '0;
	localparam logic [CSL_TIMER_W-1:0] HALF_LD =
		CSL_TIMER_W'(CSL_SCLK_HALF_CYC - 1);
	localparam logic [CSL_TIMER_W-1:0] TCL_LD = CSL_TIMER_W'(CSL_TCL_CYC - 1);
	localparam logic [CSL_TIMER_W-1:0] LATCH_LD =
		CSL_TIMER_W'(CSL_LATCH_W_CYC - 1);

	if (LEN != ((MATRIX_N == CSL_N_4X4) ? CSL_BITS_4X4 :
		CSL_BITS_WIDE)) begin : g_bad_bits
		$error("register length does not match matrix size");
	end
	// data changes with the falling clock, so half a period covers both
	if (CSL_SCLK_HALF_CYC < CSL_SETUP_CYC || CSL_SCLK_HALF_CYC < CSL_HOLD_CYC ||
		CSL_SCLK_HALF_CYC >= (1 << CSL_TIMER_W)) begin : g_bad_timing
		$error("shift clock half period does not fit the timing");
	end

	typedef struct packed {
		csl_host_state_t state;
		logic [CSL_TIMER_W-1:0] timer;
		logic [6:0] bits;
		logic [LEN-1:0] tx;
		logic [LEN-1:0] rb_shift;
		logic [CSL_BITS_WIDE-1:0] rb;
		logic [CSL_BITS_WIDE-1:0] setting;
		logic pending;
		logic done;
		logic ps;
		logic sclk;
		logic sdata;
		logic latch;
		logic meta_so;
		logic sync_so;
		logic [31:0] prdata;
	} csl_host_st_t;

	// a full load is queued out of reset: the part powers up undefined
	localparam csl_host_st_t RST = '{state: CSL_H_IDLE, pending: 1'b1,
		default: '0};

	csl_host_st_t st_ff;
	csl_host_st_t nxt_st;
	logic acc;
	logic mapped;

	assign acc = psel & penable;
	assign mapped = (paddr == CSL_REG_CTRL) || (paddr == CSL_REG_STATUS) ||
		(paddr == CSL_REG_SET_LO) || (paddr == CSL_REG_SET_HI) ||
		(paddr == CSL_REG_RB_LO) || (paddr == CSL_REG_RB_HI);
	assign pready = 1'b1;
	assign pslverr = acc & ~mapped;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.meta_so = link.cascade_serial_out;
		nxt_st.sync_so = st_ff.meta_so;
		// done clear first so a same-cycle completion still sets it
		if (acc && pwrite && paddr == CSL_REG_STATUS &&
			pwdata[CSL_STAT_DONE_BIT]) begin
			nxt_st.done = 1'b0;
		end
		case (st_ff.state)
			CSL_H_IDLE: begin
				if (st_ff.pending) begin
					nxt_st.pending = 1'b0;
					nxt_st.tx = st_ff.setting[LEN-1:0] & ~FORCED;
					nxt_st.sdata = st_ff.setting[LEN-1] & ~FORCED[LEN-1];
					nxt_st.bits = '0;
					nxt_st.timer = HALF_LD;
					nxt_st.state = CSL_H_BIT_LO;
				end
			end
			CSL_H_BIT_LO: begin
				if (st_ff.timer == '0) begin
					nxt_st.sclk = 1'b1;
					nxt_st.rb_shift = {st_ff.rb_shift[LEN-2:0], st_ff.sync_so};
					nxt_st.timer = HALF_LD;
					nxt_st.state = CSL_H_BIT_HI;
				end else begin
					nxt_st.timer = CSL_TIMER_W'(st_ff.timer - 1'b1);
				end
			end
			CSL_H_BIT_HI: begin
				if (st_ff.timer == '0) begin
					nxt_st.sclk = 1'b0;
					nxt_st.bits = 7'(st_ff.bits + 1'b1);
					nxt_st.tx = {st_ff.tx[LEN-2:0], 1'b0};
					if (st_ff.bits == 7'(LEN - 1)) begin
						nxt_st.timer = TCL_LD;
						nxt_st.state = CSL_H_GAP;
					end else begin
						nxt_st.sdata = st_ff.tx[LEN-2];
						nxt_st.timer = HALF_LD;
						nxt_st.state = CSL_H_BIT_LO;
					end
				end else begin
					nxt_st.timer = CSL_TIMER_W'(st_ff.timer - 1'b1);
				end
			end
			CSL_H_GAP: begin
				if (st_ff.timer == '0) begin
					nxt_st.latch = 1'b1;
					nxt_st.timer = LATCH_LD;
					nxt_st.state = CSL_H_PULSE;
				end else begin
					nxt_st.timer = CSL_TIMER_W'(st_ff.timer - 1'b1);
				end
			end
			CSL_H_PULSE: begin
				// the clock stays low for the whole pulse
				if (st_ff.timer == '0) begin
					nxt_st.latch = 1'b0;
					nxt_st.done = 1'b1;
					nxt_st.rb = CSL_BITS_WIDE'(st_ff.rb_shift);
					nxt_st.state = CSL_H_IDLE;
				end else begin
					nxt_st.timer = CSL_TIMER_W'(st_ff.timer - 1'b1);
				end
			end
			default: begin
				nxt_st.state = CSL_H_IDLE;
			end
		endcase
		// register writes after the fsm so a start request always sticks
		if (acc && pwrite) begin
			case (paddr)
				CSL_REG_CTRL: begin
					if (pwdata[CSL_CTRL_START_BIT]) begin
						nxt_st.pending = 1'b1;
					end
					nxt_st.ps = pwdata[CSL_CTRL_PS_BIT];
				end
				CSL_REG_SET_LO: nxt_st.setting[31:0] = pwdata;
				CSL_REG_SET_HI: nxt_st.setting[63:32] = pwdata;
				default: begin
				end
			endcase
		end
		// read data is fetched in the setup cycle, ready by the access edge
		if (psel && !penable) begin
			case (paddr)
				CSL_REG_CTRL: nxt_st.prdata = {30'h0000_0000, st_ff.ps, 1'b0};
				CSL_REG_STATUS: nxt_st.prdata = {29'h0000_0000, st_ff.ps,
					st_ff.done, (st_ff.state != CSL_H_IDLE) | st_ff.pending};
				CSL_REG_SET_LO: nxt_st.prdata = st_ff.setting[31:0];
				CSL_REG_SET_HI: nxt_st.prdata = st_ff.setting[63:32];
				CSL_REG_RB_LO: nxt_st.prdata = st_ff.rb[31:0];
				CSL_REG_RB_HI: nxt_st.prdata = st_ff.rb[63:32];
				default: nxt_st.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= RST;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign link.shift_clk = st_ff.sclk;
	assign link.serial_data = st_ff.sdata;
	assign link.latch_en = st_ff.latch;
	assign link.power_save_pin = st_ff.ps;
endmodule // csl_loader_host

// ==== src/csl_pkg.sv ====
// shared constants and types for the crosspoint switch loader
package csl_pkg;
	// matrix variants and serial word lengths
	localparam int CSL_N_8X8 = 8;
	localparam int CSL_N_6X6 = 6;
	localparam int CSL_N_4X4 = 4;
	localparam int CSL_BITS_WIDE = 64;
	localparam int CSL_BITS_4X4 = 16;
	localparam int CSL_LAYOUT_WIDE = 8;
	localparam int CSL_LAYOUT_4X4 = 4;
	// switches that do not exist on the 6x6 part, bit n-1 for switch n
	localparam logic [63:0] CSL_FORCED_LOW_6X6 = 64'h0c0c_0c0c_ffff_0c0c;
	// power save: first_path_switch is 1, second path is layout + 2
	localparam int CSL_PS_FIRST = 1;
	localparam int CSL_PS_SECOND_OFS = 2;
	// synchroniser lanes of the device
	localparam int CSL_SYNC_W = 4;
	localparam int CSL_PIN_CLK = 0;
	localparam int CSL_PIN_DATA = 1;
	localparam int CSL_PIN_LATCH = 2;
	localparam int CSL_PIN_PS = 3;
	// timing: shift clock at most 1 MHz with 50 % duty
	localparam int CSL_PCLK_NS = 8;
	localparam int CSL_SCLK_HALF_NS = 500;
	localparam int CSL_SETUP_NS = 100;
	localparam int CSL_HOLD_NS = 100;
	localparam int CSL_TCL_NS = 100;
	localparam int CSL_LATCH_W_NS = 100;
	localparam int CSL_SCLK_HALF_CYC =
		(CSL_SCLK_HALF_NS + CSL_PCLK_NS - 1) / CSL_PCLK_NS;
	localparam int CSL_SETUP_CYC =
		(CSL_SETUP_NS + CSL_PCLK_NS - 1) / CSL_PCLK_NS;
	localparam int CSL_HOLD_CYC =
		(CSL_HOLD_NS + CSL_PCLK_NS - 1) / CSL_PCLK_NS;
	localparam int CSL_TCL_CYC = (CSL_TCL_NS + CSL_PCLK_NS - 1) / CSL_PCLK_NS;
	localparam int CSL_LATCH_W_CYC =
		(CSL_LATCH_W_NS + CSL_PCLK_NS - 1) / CSL_PCLK_NS;
	localparam int CSL_TIMER_W = 8;
	// host register map over apb
	localparam int CSL_APB_AW = 12;
	localparam logic [11:0] CSL_REG_CTRL = 12'h000;
	localparam logic [11:0] CSL_REG_STATUS = 12'h004;
	localparam logic [11:0] CSL_REG_SET_LO = 12'h008;
	localparam logic [11:0] CSL_REG_SET_HI = 12'h00c;
	localparam logic [11:0] CSL_REG_RB_LO = 12'h010;
	localparam logic [11:0] CSL_REG_RB_HI = 12'h014;
	localparam int CSL_CTRL_START_BIT = 0;
	localparam int CSL_CTRL_PS_BIT = 1;
	localparam int CSL_STAT_BUSY_BIT = 0;
	localparam int CSL_STAT_DONE_BIT = 1;
	localparam int CSL_STAT_PS_BIT = 2;
	typedef enum logic [2:0] {
		CSL_H_IDLE = 3'b000,
		CSL_H_BIT_LO = 3'b001,
		CSL_H_BIT_HI = 3'b010,
		CSL_H_GAP = 3'b011,
		CSL_H_PULSE = 3'b100
	} csl_host_state_t;
endpackage

// ==== src/csl_switch_device.sv ====
// crosspoint device end: shift register, data latch, power save, cascade
`timescale 1ns/1ps
module csl_switch_device #(
	parameter int MATRIX_N = csl_pkg::CSL_N_8X8,
	parameter int LEN = (MATRIX_N == csl_pkg::CSL_N_4X4) ?
		csl_pkg::CSL_BITS_4X4 : csl_pkg::CSL_BITS_WIDE,
	parameter int LAYOUT = (MATRIX_N == csl_pkg::CSL_N_4X4) ?
		csl_pkg::CSL_LAYOUT_4X4 : csl_pkg::CSL_LAYOUT_WIDE
) (
	input logic pclk,
	input logic presetn,
	csl_link_if.dev link,
	output logic [LEN-1:0] crosspoint_switch_on,
	output logic [LAYOUT-1:0][LAYOUT-1:0] analog_output_mix,
	output logic [LAYOUT-1:0] analog_output_active,
	output logic [LAYOUT-1:0] analog_input_used,
	output logic power_save_active,
	output logic load_error,
	output logic setting_applied
);
	import csl_pkg::*;

	localparam int CW = $clog2(LEN + 2);
	localparam logic [LEN-1:0] ONE = LEN'(1);
	localparam logic [LEN-1:0] PS_PAT =
		(ONE << (CSL_PS_FIRST - 1)) |
		(ONE << (LAYOUT + CSL_PS_SECOND_OFS - 1));
	localparam logic [LEN-1:0] FORCED = (MATRIX_N == CSL_N_6X6) ?
		LEN'(CSL_FORCED_LOW_6X6) : '0;
	localparam logic [LEN-1:0] VALID = ~FORCED;

	// refuse sizes the latch layout cannot serve
	if (MATRIX_N != CSL_N_8X8 && MATRIX_N != CSL_N_6X6 &&
		MATRIX_N != CSL_N_4X4) begin : g_bad_size
		$error("unsupported crosspoint matrix size");
	end
	if (LEN != LAYOUT * LAYOUT) begin : g_bad_len
		$error("register length must equal layout squared");
	end
	if (LEN != ((MATRIX_N == CSL_N_4X4) ? CSL_BITS_4X4 :
		CSL_BITS_WIDE)) begin : g_bad_bits
		$error("register length does not match matrix size");
	end

	typedef struct packed {
		logic [CSL_SYNC_W-1:0] meta;
		logic [CSL_SYNC_W-1:0] sync;
		logic clk_prev;
		logic latch_prev;
		logic [LEN-1:0] shift;
		logic [LEN-1:0] hold;
		logic [CW-1:0] count;
		logic ps_active;
		logic load_error;
		logic applied;
	} csl_dev_state_t;

	csl_dev_state_t st_ff;
	csl_dev_state_t nxt_st;
	logic clk_s;
	logic data_s;
	logic latch_s;
	logic ps_s;
	logic clk_rise;
	logic latch_rise;
	logic latch_fall;

	// only the second synchroniser stage is read by logic
	assign clk_s = st_ff.sync[CSL_PIN_CLK];
	assign data_s = st_ff.sync[CSL_PIN_DATA];
	assign latch_s = st_ff.sync[CSL_PIN_LATCH];
	assign ps_s = st_ff.sync[CSL_PIN_PS];
	// data and clock share the same delay, so setup and hold survive
	assign clk_rise = clk_s & ~st_ff.clk_prev;
	assign latch_rise = latch_s & ~st_ff.latch_prev;
	assign latch_fall = ~latch_s & st_ff.latch_prev;

	always_comb begin
		nxt_st = st_ff;
		nxt_st.meta[CSL_PIN_CLK] = link.shift_clk;
		nxt_st.meta[CSL_PIN_DATA] = link.serial_data;
		nxt_st.meta[CSL_PIN_LATCH] = link.latch_en;
		nxt_st.meta[CSL_PIN_PS] = link.power_save_pin;
		nxt_st.sync = st_ff.meta;
		nxt_st.clk_prev = clk_s;
		nxt_st.latch_prev = latch_s;
		nxt_st.applied = 1'b0;
		nxt_st.ps_active = ps_s;

		// serial register: new bit at stage 1, oldest at the top
		if (clk_rise) begin
			nxt_st.shift = {st_ff.shift[LEN-2:0], data_s};
			if (st_ff.count != CW'(LEN + 1)) begin
				nxt_st.count = CW'(st_ff.count + 1'b1);
			end
			// clocking into an open latch corrupts the setting
			if (latch_s) begin
				nxt_st.load_error = 1'b1;
			end
		end

		// wrong clock count before the latch leaves switches undefined
		if (latch_rise) begin
			nxt_st.load_error = (st_ff.count != CW'(LEN)) | clk_rise;
			nxt_st.applied = ~ps_s;
		end
		if (latch_fall) begin
			nxt_st.count = '0;
		end

		// power save overrides; the pattern then holds until relatched
		if (ps_s) begin
			nxt_st.hold = PS_PAT & VALID;
		end else if (latch_s) begin
			nxt_st.hold = nxt_st.shift & VALID;
		end
	end

	// no reset on the real part; zero here only for a defined start
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign link.cascade_serial_out = st_ff.shift[LEN-1];
	assign crosspoint_switch_on = st_ff.hold;
	assign power_save_active = st_ff.ps_active;
	assign load_error = st_ff.load_error;
	assign setting_applied = st_ff.applied;

	// switch n = layout*(out-1) + in drives input in onto output out
	for (genvar o = 0; o < LAYOUT; o++) begin : g_out
		logic [LAYOUT-1:0] col;
		for (genvar i = 0; i < LAYOUT; i++) begin : g_in
			assign analog_output_mix[o][i] = st_ff.hold[o * LAYOUT + i];
			assign col[i] = st_ff.hold[i * LAYOUT + o];
		end
		// amplifier enables: an output with nothing routed can idle
		assign analog_output_active[o] = |st_ff.hold[o * LAYOUT +: LAYOUT];
		assign analog_input_used[o] = |col;
	end
endmodule // csl_switch_device

// ==== verif/csl_link_props.sv ====
// assertions on the serial link between loader host and device
`timescale 1ns/1ps
module csl_link_props #(
	parameter int LEN = 64
) (
	input logic pclk,
	input logic presetn,
	input logic shift_clk,
	input logic serial_data,
	input logic latch_en,
	input logic power_save_pin,
	input logic cascade_serial_out
);
	logic [7:0] rise_cnt_ff;
	logic [LEN-1:0] mdl_ff;
	logic clk_prev_ff;
	logic clk_up;
	// prev resets to the idle low level, so no false edge after reset
	assign clk_up = shift_clk & ~clk_prev_ff;
	// reference chain, zero after reset like the device model
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_cnt_ff <= 8'h00;
			mdl_ff <= '0;
			clk_prev_ff <= 1'b0;
		end else begin
			clk_prev_ff <= shift_clk;
			if (latch_en)
				rise_cnt_ff <= 8'h00;
			else if (clk_up)
				rise_cnt_ff <= rise_cnt_ff + 8'h01;
			if (clk_up)
				mdl_ff <= {mdl_ff[LEN-2:0], serial_data};
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_no_clk_latch: assert property (latch_en |-> !$rose(shift_clk))
		else $error("shift clock rose while latch high");
	a_latch_after_stop: assert property ($rose(latch_en) |->
		!shift_clk && !$past(shift_clk, 12))
		else $error("latch raised too soon after shift clock");
	a_latch_pulse: assert property ($rose(latch_en) |->
		latch_en [*8] ##[1:8] !latch_en)
		else $error("latch pulse width wrong");
	a_clk_count: assert property ($rose(latch_en) |->
		rise_cnt_ff == LEN)
		else $error("wrong number of shift clocks before latch");
	a_data_clk_low: assert property ($changed(serial_data) |->
		!shift_clk)
		else $error("serial data changed while shift clock high");
	a_clk_low_time: assert property ($fell(shift_clk) |->
		!shift_clk [*8])
		else $error("shift clock low phase too short");
	a_cascade_serial_out_timing: assert property ($changed(cascade_serial_out) |->
		shift_clk && !$past(shift_clk, 5))
		else $error("cascade output moved away from a shift edge");
	a_cascade_serial_out_value: assert property ($rose(shift_clk) |->
		##5 cascade_serial_out == mdl_ff[LEN-1])
		else $error("cascade output is not the last stage");
	c_latch: cover property ($rose(latch_en));
	c_ps_on: cover property ($rose(power_save_pin));
	c_ps_off: cover property ($fell(power_save_pin));
endmodule // csl_link_props

// ==== verif/tb.sv ====
// testbench: loader host and switch device joined over the link
`timescale 1ns/1ps
module tb;
	import csl_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [63:0] sw_on;
	logic [7:0][7:0] mix;
	logic [7:0] out_act, in_used;
	logic ps_act, ld_err, applied;
	logic pready4, pslverr4, pready6, pslverr6, rdy, rerr, ld_err4;
	logic [31:0] prdata4, prdata6, rdat;
	logic [1:0] tgt;
	logic [15:0] sw_on4;
	logic [3:0][3:0] mix4;
	logic [3:0] out_act4, in_used4;
	logic [63:0] sw_on6;
	int fail_count, n_compared, n_applied;
	csl_link_if link();
	csl_link_if link4();
	csl_link_if link6();
	csl_loader_host i_csl_loader_host (.pclk(pclk), .presetn(presetn),
		.psel(psel && tgt == 2'd0), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .link(link));
	csl_switch_device i_csl_switch_device (.pclk(pclk), .presetn(presetn),
		.link(link), .crosspoint_switch_on(sw_on), .analog_output_mix(mix),
		.analog_output_active(out_act), .analog_input_used(in_used),
		.power_save_active(ps_act), .load_error(ld_err),
		.setting_applied(applied));
	csl_loader_host #(.MATRIX_N(CSL_N_4X4)) i_csl_loader_host_4x4 (
		.pclk(pclk), .presetn(presetn), .psel(psel && tgt == 2'd1),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata4), .pready(pready4),
		.pslverr(pslverr4), .link(link4));
	csl_switch_device #(.MATRIX_N(CSL_N_4X4)) i_csl_switch_device_4x4 (
		.pclk(pclk), .presetn(presetn), .link(link4),
		.crosspoint_switch_on(sw_on4), .analog_output_mix(mix4),
		.analog_output_active(out_act4), .analog_input_used(in_used4),
		.power_save_active(), .load_error(ld_err4), .setting_applied());
	// a wide device shows exactly the bits the 6x6 host sends
	csl_loader_host #(.MATRIX_N(CSL_N_6X6)) i_csl_loader_host_6x6 (
		.pclk(pclk), .presetn(presetn), .psel(psel && tgt == 2'd2),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata6), .pready(pready6),
		.pslverr(pslverr6), .link(link6));
	csl_switch_device i_csl_switch_device_6x6 (.pclk(pclk),
		.presetn(presetn), .link(link6), .crosspoint_switch_on(sw_on6),
		.analog_output_mix(), .analog_output_active(),
		.analog_input_used(), .power_save_active(), .load_error(),
		.setting_applied());
	assign rdy = (tgt == 2'd1) ? pready4 :
		(tgt == 2'd2) ? pready6 : pready;
	assign rdat = (tgt == 2'd1) ? prdata4 :
		(tgt == 2'd2) ? prdata6 : prdata;
	assign rerr = (tgt == 2'd1) ? pslverr4 :
		(tgt == 2'd2) ? pslverr6 : pslverr;
	csl_link_props #(.LEN(64)) i_csl_link_props (.pclk(pclk),
		.presetn(presetn), .shift_clk(link.shift_clk),
		.serial_data(link.serial_data), .latch_en(link.latch_en),
		.power_save_pin(link.power_save_pin),
		.cascade_serial_out(link.cascade_serial_out));
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// pulse stands one cycle, so one look per edge counts it once
	always @(posedge pclk) begin
		if (applied === 1'b1)
			n_applied++;
	end
	task chk(input string what, input logic [63:0] seen,
		input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask
	task test_done;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a wait for ready
		do begin
			@(posedge pclk);
		end while (rdy !== 1'b1);
		rd = rdat;
		err = rerr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wait_done;
		int n;
		n = 0;
		do begin
			apb(1'b0, CSL_REG_STATUS, 32'h0000_0000);
			n++;
		end while (rd[CSL_STAT_DONE_BIT] !== 1'b1 && n < 4000);
		chk("load done", rd[CSL_STAT_DONE_BIT], 1'b1);
		apb(1'b1, CSL_REG_STATUS, 32'h0000_0002);
	endtask
	task load(input logic [31:0] lo, input logic [31:0] hi);
		apb(1'b1, CSL_REG_SET_LO, lo);
		apb(1'b1, CSL_REG_SET_HI, hi);
		apb(1'b1, CSL_REG_CTRL, 32'h0000_0001);
		wait_done();
	endtask
	task t_powerup;
		wait_done();
		chk("switches", sw_on, 64'h0000_0000_0000_0000);
		chk("load error", ld_err, 1'b0);
	endtask
	task t_pattern;
		int base;
		base = n_applied;
		load(32'h0000_0205, 32'h8000_0001);
		chk("switches", sw_on, 64'h8000_0001_0000_0205);
		chk("mix 2 2", mix[1][1], 1'b1);
		chk("mix 1 3", mix[0][2], 1'b1);
		chk("outputs", out_act, 8'h93);
		chk("inputs", in_used, 8'h87);
		chk("applied", n_applied - base, 1);
		chk("load error", ld_err, 1'b0);
	endtask
	task t_power_save;
		apb(1'b1, CSL_REG_CTRL, 32'h0000_0002);
		repeat (12) @(posedge pclk);
		chk("ps switches", sw_on, 64'h0000_0000_0000_0201);
		chk("ps active", ps_act, 1'b1);
		apb(1'b0, CSL_REG_CTRL, 32'h0000_0000);
		chk("ctrl ps", rd, 32'h0000_0002);
		apb(1'b1, CSL_REG_CTRL, 32'h0000_0000);
		repeat (12) @(posedge pclk);
		chk("after ps", sw_on, 64'h0000_0000_0000_0201);
		chk("ps inactive", ps_act, 1'b0);
	endtask
	task t_reload;
		load(32'hffff_ffff, 32'hffff_ffff);
		chk("all on", sw_on, 64'hffff_ffff_ffff_ffff);
		apb(1'b0, CSL_REG_RB_LO, 32'h0000_0000);
		chk("cascade lo", rd, 32'h0000_0205);
		apb(1'b0, CSL_REG_RB_HI, 32'h0000_0000);
		chk("cascade hi", rd, 32'h8000_0001);
	endtask
	task t_unmapped;
		apb(1'b0, 12'h020, 32'h0000_0000);
		chk("unmapped data", rd, 32'h0000_0000);
		chk("unmapped err", err, 1'b1);
		apb(1'b0, CSL_REG_SET_HI, 32'h0000_0000);
		chk("mapped err", err, 1'b0);
		chk("set hi", rd, 32'hffff_ffff);
	endtask
	// the small and the 6x6 host; their power-up done is cleared first
	task t_variants;
		tgt <= 2'd1;
		wait_done();
		load(32'h0000_0306, 32'h0000_0000);
		chk("4x4 switches", sw_on4, 64'h0000_0000_0000_0306);
		chk("4x4 load error", ld_err4, 1'b0);
		chk("4x4 mix 3 2", mix4[2][1], 1'b1);
		chk("4x4 outputs", out_act4, 4'h5);
		chk("4x4 inputs", in_used4, 4'h7);
		apb(1'b1, CSL_REG_CTRL, 32'h0000_0002);
		repeat (12) @(posedge pclk);
		chk("4x4 ps switches", sw_on4, 64'h0000_0000_0000_0021);
		apb(1'b1, CSL_REG_CTRL, 32'h0000_0000);
		tgt <= 2'd2;
		wait_done();
		load(32'hffff_ffff, 32'hffff_ffff);
		chk("6x6 sent bits", sw_on6, 64'hf3f3_f3f3_0000_f3f3);
		tgt <= 2'd0;
	endtask
	// four full loads and one short take about 35000 cycles
	initial begin
		repeat (60000) @(posedge pclk);
		fail_count++;
		test_done();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		tgt = 2'd0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_powerup();
		t_pattern();
		t_power_save();
		t_reload();
		t_unmapped();
		t_variants();
		test_done();
	end
endmodule // tb
